// file: hw/mesf_pkg.sv
// Purpose: Shared constants and types of the meter event status flag block.
// Assumes: APB byte address of a register is four times its index.
// Notes:   Every register index, field start bit, config reset value and settle count is named here.

`default_nettype none

package mesf_pkg;

    // APB address width; wide enough for four times the largest index.
    localparam int          ADDR_W = 18;
    localparam int          DATA_W = 32;
    localparam int          IDX_W  = 16;

    // Register indices; the byte address is the index shifted left by two.
    localparam logic [15:0] IDX_EVENT_STATUS = 16'he502;
    localparam logic [15:0] IDX_LOAD_STATUS  = 16'he503;
    localparam logic [15:0] IDX_NOLOAD_PHASE = 16'he608;
    localparam logic [15:0] IDX_PULSE_CFG    = 16'he610;
    localparam logic [15:0] IDX_POWER_SIGN   = 16'he617;
    localparam logic [15:0] IDX_HARM_CFG     = 16'he900;

    // Event status word bit positions.
    localparam int          BIT_PATH2_SUM_SIGN_FLIP = 13;
    localparam int          BIT_PULSE_OUT_ONE       = 14;
    localparam int          BIT_PULSE_OUT_TWO       = 15;
    localparam int          BIT_PULSE_OUT_THREE     = 16;
    localparam int          BIT_DSP_CYCLE_DONE      = 17;
    localparam int          BIT_PATH3_SUM_SIGN_FLIP = 18;
    localparam int          BIT_HARMONIC_READY      = 19;

    // Load and crossing status word bit positions.
    localparam int          BIT_TOTAL_NOLOAD        = 0;
    localparam int          BIT_FUND_NOLOAD         = 1;
    localparam int          BIT_APPARENT_NOLOAD     = 2;
    localparam int          BIT_VOLT_A_MISSING      = 3;
    localparam int          BIT_CURR_A_MISSING      = 6;

    // Pulse configuration fields.
    localparam int          POS_PULSE_ONE_SOURCE    = 0;
    localparam int          POS_PULSE_TWO_SOURCE    = 3;
    localparam int          POS_PULSE_THREE_SOURCE  = 6;
    localparam int          POS_PULSE_ONE_DISABLE   = 9;
    localparam int          PULSE_CFG_W             = 12;

    // Sign register fields.
    localparam int          POS_PATH2_SUM_SIGN      = 7;
    localparam int          POS_PATH3_SUM_SIGN      = 8;

    // Harmonic configuration fields.
    localparam int          POS_HARM_TIMING_SEL     = 1;
    localparam int          POS_HARM_SETTLE         = 3;
    localparam int          POS_HARM_RATE           = 5;
    localparam int          HARM_CFG_W              = 8;

    // No-load phase register fields.
    localparam int          POS_TOTAL_NOLOAD_PHASE    = 0;
    localparam int          POS_FUND_NOLOAD_PHASE     = 3;
    localparam int          POS_APPARENT_NOLOAD_PHASE = 6;

    // Reset values.
    localparam logic [31:0] STATUS_RST    = 32'h0000_0000;
    localparam logic [11:0] PULSE_CFG_RST = 12'h000;
    localparam logic [7:0]  HARM_CFG_RST  = 8'h00;

    // Settling delay, in signal-processing cycles, per settle field value.
    localparam logic [15:0] SETTLE_TICKS_0 = 16'h0100;
    localparam logic [15:0] SETTLE_TICKS_1 = 16'h0200;
    localparam logic [15:0] SETTLE_TICKS_2 = 16'h0400;
    localparam logic [15:0] SETTLE_TICKS_3 = 16'h0800;

    // Events from the metering datapath, all on the block clock.
    typedef struct packed {
        logic [2:0] pulse_raw;
        logic       path2_sum_sign;
        logic       path3_sum_sign;
        logic       dsp_cycle_done;
        logic [2:0] total_noload_phase;
        logic [2:0] fund_noload_phase;
        logic [2:0] apparent_noload_phase;
        logic [2:0] volt_crossing_missing;
        logic       curr_a_crossing_missing;
    } mesf_events_type;

    typedef struct packed {
        logic [2:0] pulse_three_source;
        logic [2:0] pulse_two_source;
        logic [2:0] pulse_one_source;
    } mesf_pulse_sel_type;

    typedef enum {
        HARM_IDLE,
        HARM_SETTLE,
        HARM_RUN
    } mesf_harm_state_type;

endpackage

`default_nettype wire

// file: hw/mesf_flag_bank.sv
// Purpose: Bank of sticky status flags, set by events, cleared by writes.
// Assumes: Set and clear vectors are on the same clock as the bank.
// Notes:   A set in the cycle of a clear keeps the flag high.

`default_nettype none

module mesf_flag_bank #(
    parameter int W = 32
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] set_i,
    input  wire logic [W-1:0] clear_i,
    output var  logic [W-1:0] flags_o
);

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_flag
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    flags_o[i] <= 1'b0;
                end else if (set_i[i]) begin
                    flags_o[i] <= 1'b1;
                end else if (clear_i[i]) begin
                    flags_o[i] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// file: hw/mesf_status_top.sv
// Purpose: Event status flags of a polyphase meter, reached over APB.
// Assumes: Datapath events arrive on CLK_I; APB runs on CLK_I too.
// Notes:   Zero wait states; unmapped or misaligned access gives PSLVERR.
//
// How it works
// - A sign flip of the path two power sum sets bit 13, sign in bit 7.
// - Pulse output one falling sets bit 14 even if bit 9 disables it.
// - Pulse output two falling sets bit 15 even if bit 10 disables it.
// - Pulse output three falling sets bit 16 even if bit 11 disables it.
// - Fields [2:0], [5:3] and [8:6] choose the power type of each output.
// - Completion of each 8 kHz signal-processing cycle sets event bit 17.
// - A sign flip of the path three power sum sets bit 18, sign in bit 8.
// - Select clear: bit 19 sets at rate [7:5] updates after delay [4:3].
// - With bit 1 set, bit 19 sets at each update right after setup.
// - The load and crossing status word sits at index 0xe503.
// - A phase entering total no-load sets bit 0, phase at [2:0].
// - A phase entering fundamental no-load sets bit 1, phase at [5:3].
// - A phase entering apparent no-load sets bit 2, phase at [8:6].
// - A missing zero crossing on voltage A, B or C sets bit 3, 4 or 5.
// - A missing zero crossing on current A sets bit 6.

`default_nettype none

module mesf_status_top (
    input  wire logic                         CLK_I,
    input  wire logic                         SYS_RST_I,
    input  wire logic                         PSEL_I,
    input  wire logic                         PENABLE_I,
    input  wire logic                         PWRITE_I,
    input  wire logic [mesf_pkg::ADDR_W-1:0]  PADDR_I,
    input  wire logic [mesf_pkg::DATA_W-1:0]  PWDATA_I,
    output var  logic [mesf_pkg::DATA_W-1:0]  PRDATA_O,
    output var  logic                         PREADY_O,
    output var  logic                         PSLVERR_O,
    input  wire mesf_pkg::mesf_events_type    EVENTS_I,
    output var  logic [2:0]                   PULSE_O,
    output var  mesf_pkg::mesf_pulse_sel_type PULSE_SEL_O,
    output var  logic                         HARM_UPDATE_O
);

    // Bus decode.
    logic                         setup;
    logic                         access;
    logic                         wr_access;
    logic [mesf_pkg::IDX_W-1:0]   idx;
    logic                         aligned;
    logic                         hit_event;
    logic                         hit_load;
    logic                         hit_noload;
    logic                         hit_pulse;
    logic                         hit_sign;
    logic                         hit_harm;
    logic                         hit_any;
    logic                         bad_access;
    logic [mesf_pkg::DATA_W-1:0]  next_rdata;

    // Control registers.
    logic [mesf_pkg::PULSE_CFG_W-1:0] pulse_config_reg;
    logic [mesf_pkg::HARM_CFG_W-1:0]  harmonic_config_reg;
    logic                             harm_cfg_write;

    // Event detection.
    logic [2:0]                   pulse_prev;
    logic [2:0]                   pulse_fall;
    logic                         path2_sum_sign;
    logic                         path3_sum_sign;
    logic                         path2_sum_sign_flip;
    logic                         path3_sum_sign_flip;
    logic [8:0]                   noload_prev;
    logic [8:0]                   noload_now;
    logic                         total_noload_flag;
    logic                         fund_noload_flag;
    logic                         apparent_noload_flag;
    logic [mesf_pkg::DATA_W-1:0]  event_set;
    logic [mesf_pkg::DATA_W-1:0]  load_set;
    logic [mesf_pkg::DATA_W-1:0]  event_clear;
    logic [mesf_pkg::DATA_W-1:0]  load_clear;
    logic [mesf_pkg::DATA_W-1:0]  event_flags;
    logic [mesf_pkg::DATA_W-1:0]  load_flags;
    logic [mesf_pkg::DATA_W-1:0]  power_sign_reg;
    logic [mesf_pkg::DATA_W-1:0]  noload_phase_reg;

    // Harmonic update timing.
    mesf_pkg::mesf_harm_state_type harm_state;
    logic [15:0]                   settle_cnt;
    logic [15:0]                   settle_target;
    logic [7:0]                    rate_cnt;
    logic [7:0]                    rate_period;
    logic                          harm_timing_sel;
    logic [1:0]                    harmonic_settle_delay;
    logic [2:0]                    harmonic_update_rate;
    logic                          harm_update;

    // ---------------------------------------------------------------
    // APB slave. Read data is captured in the setup cycle so that it
    // comes from a flip-flop while the access still needs no wait.
    // ---------------------------------------------------------------
    assign setup     = PSEL_I & ~PENABLE_I;
    assign access    = PSEL_I & PENABLE_I;
    assign idx       = PADDR_I[mesf_pkg::ADDR_W-1:2];
    assign aligned   = (PADDR_I[1:0] == 2'h0);
    assign hit_event = aligned & (idx == mesf_pkg::IDX_EVENT_STATUS);
    assign hit_load  = aligned & (idx == mesf_pkg::IDX_LOAD_STATUS);
    assign hit_noload = aligned & (idx == mesf_pkg::IDX_NOLOAD_PHASE);
    assign hit_pulse = aligned & (idx == mesf_pkg::IDX_PULSE_CFG);
    assign hit_sign  = aligned & (idx == mesf_pkg::IDX_POWER_SIGN);
    assign hit_harm  = aligned & (idx == mesf_pkg::IDX_HARM_CFG);
    assign hit_any   = hit_event | hit_load | hit_noload | hit_pulse
                     | hit_sign | hit_harm;
    assign wr_access = access & PWRITE_I & hit_any;
    assign PREADY_O  = 1'b1;

    always_comb begin
        next_rdata = '0;
        if (hit_event) begin
            next_rdata = event_flags;
        end else if (hit_load) begin
            next_rdata = load_flags;
        end else if (hit_noload) begin
            next_rdata = noload_phase_reg;
        end else if (hit_pulse) begin
            next_rdata[mesf_pkg::PULSE_CFG_W-1:0] = pulse_config_reg;
        end else if (hit_sign) begin
            next_rdata = power_sign_reg;
        end else if (hit_harm) begin
            next_rdata[mesf_pkg::HARM_CFG_W-1:0] = harmonic_config_reg;
        end
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            PRDATA_O   <= '0;
            bad_access <= 1'b0;
        end else if (setup) begin
            PRDATA_O   <= PWRITE_I ? '0 : next_rdata;
            bad_access <= ~hit_any;
        end
    end

    assign PSLVERR_O = access & bad_access;

    // ---------------------------------------------------------------
    // Configuration registers.
    // ---------------------------------------------------------------
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            pulse_config_reg <= mesf_pkg::PULSE_CFG_RST;
        end else if (wr_access & hit_pulse) begin
            pulse_config_reg <= PWDATA_I[mesf_pkg::PULSE_CFG_W-1:0];
        end
    end

    // Bit 0 and bit 2 have no function and stay zero.
    assign harm_cfg_write = wr_access & hit_harm;

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            harmonic_config_reg <= mesf_pkg::HARM_CFG_RST;
        end else if (harm_cfg_write) begin
            harmonic_config_reg <= PWDATA_I[mesf_pkg::HARM_CFG_W-1:0]
                                 & 8'hfa;
        end
    end

    assign PULSE_SEL_O.pulse_one_source   =
        pulse_config_reg[mesf_pkg::POS_PULSE_ONE_SOURCE +: 3];
    assign PULSE_SEL_O.pulse_two_source   =
        pulse_config_reg[mesf_pkg::POS_PULSE_TWO_SOURCE +: 3];
    assign PULSE_SEL_O.pulse_three_source =
        pulse_config_reg[mesf_pkg::POS_PULSE_THREE_SOURCE +: 3];

    // ---------------------------------------------------------------
    // Pulse outputs. A disabled output idles high, but the edge detect
    // looks at the undisabled pulse, so the flag still reports it.
    // ---------------------------------------------------------------
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            pulse_prev <= 3'h7;
            PULSE_O    <= 3'h7;
        end else begin
            pulse_prev <= EVENTS_I.pulse_raw;
            PULSE_O    <= EVENTS_I.pulse_raw |
                pulse_config_reg[mesf_pkg::POS_PULSE_ONE_DISABLE +: 3];
        end
    end

    assign pulse_fall = pulse_prev & ~EVENTS_I.pulse_raw;

    // ---------------------------------------------------------------
    // Sign of the summed powers of paths two and three.
    // ---------------------------------------------------------------
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            path2_sum_sign <= 1'b0;
            path3_sum_sign <= 1'b0;
        end else begin
            path2_sum_sign <= EVENTS_I.path2_sum_sign;
            path3_sum_sign <= EVENTS_I.path3_sum_sign;
        end
    end

    assign path2_sum_sign_flip = path2_sum_sign ^ EVENTS_I.path2_sum_sign;
    assign path3_sum_sign_flip = path3_sum_sign ^ EVENTS_I.path3_sum_sign;

    always_comb begin
        power_sign_reg = '0;
        power_sign_reg[mesf_pkg::POS_PATH2_SUM_SIGN] = path2_sum_sign;
        power_sign_reg[mesf_pkg::POS_PATH3_SUM_SIGN] = path3_sum_sign;
    end

    // ---------------------------------------------------------------
    // No-load entry: only a phase newly entering no-load raises a flag.
    // ---------------------------------------------------------------
    assign noload_now = {EVENTS_I.apparent_noload_phase,
                         EVENTS_I.fund_noload_phase,
                         EVENTS_I.total_noload_phase};

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            noload_prev <= 9'h000;
        end else begin
            noload_prev <= noload_now;
        end
    end

    assign total_noload_flag    = |(noload_now[2:0] & ~noload_prev[2:0]);
    assign fund_noload_flag     = |(noload_now[5:3] & ~noload_prev[5:3]);
    assign apparent_noload_flag = |(noload_now[8:6] & ~noload_prev[8:6]);

    always_comb begin
        noload_phase_reg = '0;
        noload_phase_reg[mesf_pkg::POS_TOTAL_NOLOAD_PHASE +: 3] =
            noload_prev[2:0];
        noload_phase_reg[mesf_pkg::POS_FUND_NOLOAD_PHASE +: 3] =
            noload_prev[5:3];
        noload_phase_reg[mesf_pkg::POS_APPARENT_NOLOAD_PHASE +: 3] =
            noload_prev[8:6];
    end

    // ---------------------------------------------------------------
    // Harmonic update timing. A write of the harmonic configuration is
    // the block setup and restarts the schedule. Delays count finished
    // signal-processing cycles, not clock cycles.
    // ---------------------------------------------------------------
    assign harm_timing_sel       =
        harmonic_config_reg[mesf_pkg::POS_HARM_TIMING_SEL];
    assign harmonic_settle_delay =
        harmonic_config_reg[mesf_pkg::POS_HARM_SETTLE +: 2];
    assign harmonic_update_rate  =
        harmonic_config_reg[mesf_pkg::POS_HARM_RATE +: 3];
    assign rate_period           = 8'h01 << harmonic_update_rate;

    always_comb begin
        case (harmonic_settle_delay)
            2'h0:    settle_target = mesf_pkg::SETTLE_TICKS_0;
            2'h1:    settle_target = mesf_pkg::SETTLE_TICKS_1;
            2'h2:    settle_target = mesf_pkg::SETTLE_TICKS_2;
            default: settle_target = mesf_pkg::SETTLE_TICKS_3;
        endcase
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            harm_state <= mesf_pkg::HARM_IDLE;
            settle_cnt <= 16'h0000;
        end else if (harm_cfg_write) begin
            settle_cnt <= 16'h0000;
            if (PWDATA_I[mesf_pkg::POS_HARM_TIMING_SEL]) begin
                harm_state <= mesf_pkg::HARM_RUN;
            end else begin
                harm_state <= mesf_pkg::HARM_SETTLE;
            end
        end else begin
            case (harm_state)
                mesf_pkg::HARM_SETTLE: begin
                    if (EVENTS_I.dsp_cycle_done) begin
                        if (settle_cnt == settle_target - 16'h0001) begin
                            harm_state <= mesf_pkg::HARM_RUN;
                        end
                        settle_cnt <= settle_cnt + 16'h0001;
                    end
                end
                mesf_pkg::HARM_RUN: begin
                    harm_state <= mesf_pkg::HARM_RUN;
                end
                default: begin
                    harm_state <= mesf_pkg::HARM_IDLE;
                end
            endcase
        end
    end

    assign harm_update = (harm_state == mesf_pkg::HARM_RUN)
                       & EVENTS_I.dsp_cycle_done
                       & (rate_cnt == rate_period - 8'h01);

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            rate_cnt <= 8'h00;
        end else if (harm_cfg_write || harm_update) begin
            rate_cnt <= 8'h00;
        end else if ((harm_state == mesf_pkg::HARM_RUN)
                     && EVENTS_I.dsp_cycle_done) begin
            rate_cnt <= rate_cnt + 8'h01;
        end
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            HARM_UPDATE_O <= 1'b0;
        end else begin
            HARM_UPDATE_O <= harm_update;
        end
    end

    // ---------------------------------------------------------------
    // Event vectors into the sticky flag banks.
    // ---------------------------------------------------------------
    always_comb begin
        event_set = '0;
        event_set[mesf_pkg::BIT_PATH2_SUM_SIGN_FLIP] =
            path2_sum_sign_flip;
        event_set[mesf_pkg::BIT_PULSE_OUT_ONE]   = pulse_fall[0];
        event_set[mesf_pkg::BIT_PULSE_OUT_TWO]   = pulse_fall[1];
        event_set[mesf_pkg::BIT_PULSE_OUT_THREE] = pulse_fall[2];
        event_set[mesf_pkg::BIT_DSP_CYCLE_DONE]  =
            EVENTS_I.dsp_cycle_done;
        event_set[mesf_pkg::BIT_PATH3_SUM_SIGN_FLIP] =
            path3_sum_sign_flip;
        event_set[mesf_pkg::BIT_HARMONIC_READY]  = harm_update;
    end

    always_comb begin
        load_set = '0;
        load_set[mesf_pkg::BIT_TOTAL_NOLOAD] = total_noload_flag;
        load_set[mesf_pkg::BIT_FUND_NOLOAD] = fund_noload_flag;
        load_set[mesf_pkg::BIT_APPARENT_NOLOAD] =
            apparent_noload_flag;
        load_set[mesf_pkg::BIT_VOLT_A_MISSING +: 3] =
            EVENTS_I.volt_crossing_missing;
        load_set[mesf_pkg::BIT_CURR_A_MISSING] =
            EVENTS_I.curr_a_crossing_missing;
    end

    assign event_clear = (wr_access & hit_event) ? PWDATA_I : '0;
    assign load_clear  = (wr_access & hit_load)  ? PWDATA_I : '0;

    mesf_flag_bank #(
        .W       (mesf_pkg::DATA_W)
    ) u_event_flags (
        .clk_i   (CLK_I),
        .rst_i   (SYS_RST_I),
        .set_i   (event_set),
        .clear_i (event_clear),
        .flags_o (event_flags)
    );

    mesf_flag_bank #(
        .W       (mesf_pkg::DATA_W)
    ) u_load_flags (
        .clk_i   (CLK_I),
        .rst_i   (SYS_RST_I),
        .set_i   (load_set),
        .clear_i (load_clear),
        .flags_o (load_flags)
    );

endmodule

`default_nettype wire

// file: verification/mesf_status_sva.sv
// Purpose: Port-level checks of the meter event status flag block.
// Assumes: One clock; asynchronous active-high reset.
// Notes:   Attached by bind from the bench top file.
`default_nettype none
module mesf_status_sva (
    input wire logic                         CLK_I,
    input wire logic                         SYS_RST_I,
    input wire logic                         PSEL_I,
    input wire logic                         PENABLE_I,
    input wire logic                         PWRITE_I,
    input wire logic [mesf_pkg::ADDR_W-1:0]  PADDR_I,
    input wire logic [mesf_pkg::DATA_W-1:0]  PWDATA_I,
    input wire logic [mesf_pkg::DATA_W-1:0]  PRDATA_O,
    input wire logic                         PREADY_O,
    input wire logic                         PSLVERR_O,
    input wire mesf_pkg::mesf_events_type    EVENTS_I,
    input wire logic [2:0]                   PULSE_O,
    input wire mesf_pkg::mesf_pulse_sel_type PULSE_SEL_O,
    input wire logic                         HARM_UPDATE_O
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);
    logic cfg_wr;
    assign cfg_wr = PSEL_I && PENABLE_I && PWRITE_I
                    && PADDR_I == {mesf_pkg::IDX_PULSE_CFG, 2'b00};
    err_only_access_a: assert property (
        PSLVERR_O |-> PSEL_I && PENABLE_I) else $error("error outside access");
    miss_err_a: assert property (PSEL_I && PENABLE_I
        && (PADDR_I[1:0] != 2'b00 || PADDR_I[17:2] == 16'h0000)
        |-> PSLVERR_O && PRDATA_O == '0) else $error("miss not refused");
    sel_update_a: assert property (cfg_wr
        |=> PULSE_SEL_O == $past(PWDATA_I[8:0])) else $error("source not set");
    sel_hold_a: assert property (!cfg_wr |=> $stable(PULSE_SEL_O))
        else $error("source changed without write");
    pin_one_a: assert property (!PULSE_O[0]
        |-> !$past(EVENTS_I.pulse_raw[0])) else $error("pin one low");
    pin_two_a: assert property (!PULSE_O[1]
        |-> !$past(EVENTS_I.pulse_raw[1])) else $error("pin two low");
    pin_three_a: assert property (!PULSE_O[2]
        |-> !$past(EVENTS_I.pulse_raw[2])) else $error("pin three low");
    harm_pulse_a: assert property (HARM_UPDATE_O
        |-> $past(EVENTS_I.dsp_cycle_done)) else $error("stray update");
    cover property (HARM_UPDATE_O);
    cover property (PSLVERR_O);
    cover property (cfg_wr);
endmodule
`default_nettype wire

// file: verification/mesf_host.sv
// Purpose: APB host model that reads and clears the status flags.
// Assumes: The slave may insert wait states; each wait is bounded.
// Notes:   Signals change only by non-blocking assignment after an edge.
`default_nettype none
module mesf_host (
    input  wire logic        clk_i,
    input  wire logic        pready_i,
    input  wire logic        pslverr_i,
    input  wire logic [31:0] prdata_i,
    output var  logic        psel_o,
    output var  logic        penable_o,
    output var  logic        pwrite_o,
    output var  logic [17:0] paddr_o,
    output var  logic [31:0] pwdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} = '0;
    // A zero write never clears a flag.
    task automatic xfer(input logic w, input logic [15:0] idx,
        input logic [31:0] wd, output logic [31:0] rd, output logic err,
        output logic ok);
        int n;
        @(posedge clk_i);
        {psel_o, pwrite_o, paddr_o, pwdata_o} <= {1'b1, w, idx, 2'b00, wd};
        @(posedge clk_i);
        penable_o <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_i !== 1'b1 && n < 50);
        rd = prdata_i;
        err = pslverr_i;
        ok = n < 50;
        {psel_o, penable_o} <= 2'b00;
    endtask
endmodule
`default_nettype wire

// file: verification/mesf_status_top_test.sv
// Purpose: Self-checking bench of the meter event status flag block.
// Assumes: Zero-wait APB slave; datapath events driven on the clock edge.
// Notes:   Settling is checked with the shortest delay setting.
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_total++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module mesf_status_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst = 1'b1, psel, pen, pwr, pready, pslverr, harm, serr;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [2:0] pulse;
    mesf_pkg::mesf_events_type ev = '{pulse_raw: 3'b111, default: '0};
    mesf_pkg::mesf_pulse_sel_type sel;
    int err_total = 0, compares = 0;
    always #50 clk = ~clk;
    mesf_host u_host (.clk_i(clk), .pready_i(pready), .pslverr_i(pslverr),
        .prdata_i(prdata), .psel_o(psel), .penable_o(pen), .pwrite_o(pwr),
        .paddr_o(paddr), .pwdata_o(pwdata));
    mesf_status_top u_dut (.CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .EVENTS_I(ev), .PULSE_O(pulse), .PULSE_SEL_O(sel),
        .HARM_UPDATE_O(harm));
    task automatic end_of_test();
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic acc(input logic w, input logic [15:0] i, input int d);
        logic ok;
        u_host.xfer(w, i, d, rdat, serr, ok);
        @(negedge clk);
        if (!ok) begin
            err_total++;
            end_of_test();
        end
    endtask
    task automatic done(input int n);
        repeat (n) begin
            @(posedge clk) ev.dsp_cycle_done <= 1'b1;
            @(posedge clk) ev.dsp_cycle_done <= 1'b0;
        end
    endtask
    task automatic t_pulse();
        acc(1, mesf_pkg::IDX_PULSE_CFG, 32'h0000_0ed1);
        `CHK(sel, 9'h0d1);
        @(posedge clk) ev.pulse_raw <= 3'b000;
        @(posedge clk) ev.pulse_raw <= 3'b111;
        @(negedge clk) `CHK(pulse, 3'b111);
        acc(1, mesf_pkg::IDX_EVENT_STATUS, 32'h0);
        acc(0, mesf_pkg::IDX_EVENT_STATUS, 0);
        `CHK(rdat[16:14], 3'b111);
        acc(1, mesf_pkg::IDX_EVENT_STATUS, 32'h0001_c000);
        acc(0, mesf_pkg::IDX_EVENT_STATUS, 0);
        `CHK(rdat, 32'h0);
    endtask
    task automatic t_sign_load();
        @(posedge clk) ev <= '{3'b111, 1'b1, 1'b1, 1'b0, 3'b001, 3'b010,
            3'b100, 3'b111, 1'b1};
        @(posedge clk) {ev.volt_crossing_missing, ev.curr_a_crossing_missing}
            <= 4'h0;
        acc(0, mesf_pkg::IDX_EVENT_STATUS, 0);
        `CHK(rdat, 32'h0004_2000);
        acc(0, mesf_pkg::IDX_POWER_SIGN, 0);
        `CHK(rdat[8:7], 2'b11);
        acc(0, mesf_pkg::IDX_LOAD_STATUS, 0);
        `CHK(rdat, 32'h0000_007f);
        acc(0, mesf_pkg::IDX_NOLOAD_PHASE, 0);
        `CHK(rdat[8:0], 9'h111);
        acc(0, 16'h0000, 0);
        `CHK(serr, 1'b1);
    endtask
    task automatic t_harm();
        acc(1, mesf_pkg::IDX_HARM_CFG, 32'h0000_0002);
        done(1);
        acc(0, mesf_pkg::IDX_EVENT_STATUS, 0);
        `CHK(rdat[19:17], 3'b111);
        // The cycle pulse lands in the access cycle of the clearing write.
        fork
            acc(1, mesf_pkg::IDX_EVENT_STATUS, 32'h000a_0000);
            begin
                repeat (2) @(posedge clk);
                ev.dsp_cycle_done <= 1'b1;
                @(posedge clk) ev.dsp_cycle_done <= 1'b0;
            end
        join
        acc(0, mesf_pkg::IDX_EVENT_STATUS, 0);
        `CHK(rdat[19:17], 3'b111);
        acc(1, mesf_pkg::IDX_HARM_CFG, 32'h0000_0000);
        acc(1, mesf_pkg::IDX_EVENT_STATUS, 32'h000a_0000);
        done(200);
        acc(0, mesf_pkg::IDX_EVENT_STATUS, 0);
        `CHK(rdat[19], 1'b0);
        done(100);
        acc(0, mesf_pkg::IDX_EVENT_STATUS, 0);
        `CHK(rdat[19], 1'b1);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        acc(0, mesf_pkg::IDX_EVENT_STATUS, 0);
        `CHK(rdat, 32'h0);
        t_pulse();
        t_sign_load();
        t_harm();
        end_of_test();
    end
endmodule
bind mesf_status_top mesf_status_sva u_sva (.CLK_I(CLK_I),
    .SYS_RST_I(SYS_RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
    .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .EVENTS_I(EVENTS_I), .PULSE_O(PULSE_O), .PULSE_SEL_O(PULSE_SEL_O),
    .HARM_UPDATE_O(HARM_UPDATE_O));
`default_nettype wire
